// File: bench/nic_host_model.sv
// Host bus master model for the paged register bank.
// Assumes the bench calls its tasks after reset; strobes change on rising edges only.
`timescale 1ns/1ps
module nic_host_model (
  input wire logic CLK,
  output logic [3:0] ADDR,
  output logic RD_STB,
  output logic WR_STB,
  output logic [7:0] WDATA
);
  logic [1:0] page_q = 2'h0;

  initial begin
    ADDR = 4'h0;
    RD_STB = 1'b0;
    WR_STB = 1'b0;
    WDATA = 8'h00;
  end

  // ==========================================================================
  // Bus cycles
  // ==========================================================================
  // One access per clock; a following call keeps the strobe up back to back, except a page 3 write to offset 7, which drops both strobes.
  task automatic xfer(input logic wr, input logic [3:0] a, input logic [7:0] d);
    @(posedge CLK);
    if (wr && page_q == 2'h3 && a == 4'h7) begin
      RD_STB <= 1'b0;
      WR_STB <= 1'b0;
    end else begin
      RD_STB <= !wr;
      WR_STB <= wr;
    end
    ADDR <= a;
    WDATA <= wr ? d : ~WDATA;
    if (wr && a == 4'h0) begin
      page_q = d[7:6];
    end
  endtask

  task automatic idle();
    @(posedge CLK);
    RD_STB <= 1'b0;
    WR_STB <= 1'b0;
  endtask
endmodule

// File: bench/testbench.sv
// Self-checking bench for the paged register bank.
// Assumes the host model drives the bus; reads are checked one cycle after the strobe.
`timescale 1ns/1ps
module testbench;
  logic CLK = 1'b0;
  logic NRST = 1'b0;
  logic [3:0] ADDR;
  logic RD_STB;
  logic WR_STB;
  logic [7:0] WDATA;
  logic [7:0] RDATA;
  nic_regs_pkg::page0_view_type VIEW;
  nic_regs_pkg::status_in_type STATUS;
  nic_regs_pkg::command_type COMMAND;
  nic_regs_pkg::config_out_type CONFIG;
  int n_errors = 0;
  int tests_run = 0;
  logic [15:0] lfsr_q = 16'he8d5;
  logic [7:0] exp_q[$];
  logic rd_pend = 1'b0;

  always #2.5 CLK = ~CLK;

  nic_host_model host (.CLK(CLK), .ADDR(ADDR), .RD_STB(RD_STB), .WR_STB(WR_STB), .WDATA(WDATA));

  paged_nic_register_bank dut (.CLK(CLK), .NRST(NRST), .ADDR(ADDR), .RD_STB(RD_STB),
    .WR_STB(WR_STB), .WDATA(WDATA), .RDATA(RDATA), .VIEW(VIEW), .STATUS(STATUS),
    .COMMAND(COMMAND), .CONFIG(CONFIG));

  // ==========================================================================
  // Helpers
  // ==========================================================================
  function automatic logic [15:0] rnd();
    lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
    return lfsr_q;
  endfunction

  task automatic check(input string nm, input logic [63:0] e, input logic [63:0] g);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    host.xfer(1'b1, a, d);
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host.xfer(1'b0, a, 8'h00);
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Read data is looked at on the edge after the strobe, before it can change.
  always @(posedge CLK) begin
    if (rd_pend) begin
      if (exp_q.size() == 0) begin
        check("read queue", 64'h1, 64'h0);
      end else begin
        check("RDATA", {56'h0, exp_q.pop_front()}, {56'h0, RDATA});
      end
    end
    rd_pend <= RD_STB;
  end

  initial begin
    #20000;
    n_errors++;
    $display("watchdog expired");
    finish_test();
  end

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    logic [63:0] r;
    logic [7:0] v [16];
    logic [7:0] bp;
    r = {rnd(), rnd(), rnd(), rnd()};
    VIEW = r[55:0];
    r = {rnd(), rnd(), rnd(), rnd()};
    STATUS = r[45:0];
    repeat (10) @(posedge CLK);
    check("COMMAND", 64'h21, {56'h0, COMMAND});
    check("CONFIG zero", 64'h1, {63'h0, CONFIG === '0});
    NRST <= 1'b1;
    repeat (3) @(posedge CLK);
    wr(4'h0, 8'h62);
    for (int i = 1; i < 16; i++) begin
      r = {48'h0, rnd()};
      v[i] = r[7:0];
      wr(i[3:0], v[i]);
    end
    for (int i = 1; i < 16; i++) begin
      rd(i[3:0], v[i]);
    end
    rd(4'h0, 8'h62);
    host.idle();
    check("station", {16'h0, v[6], v[5], v[4], v[3], v[2], v[1]},
      {16'h0, CONFIG.station_address});
    check("current page", {56'h0, v[7]}, {56'h0, CONFIG.current_receive_page});
    check("filter", {v[15], v[14], v[13], v[12], v[11], v[10], v[9], v[8]},
      CONFIG.multicast_filter);
    $display("page 1 test done");
    wr(4'h0, 8'ha2);
    rd(4'h1, VIEW.ring_start_page);
    wr(4'h1, 8'h55);
    rd(4'h1, VIEW.ring_start_page);
    rd(4'h2, VIEW.ring_stop_page);
    rd(4'h4, VIEW.transmit_start_page);
    rd(4'hc, VIEW.receive_config);
    rd(4'hd, VIEW.transmit_config);
    rd(4'he, VIEW.data_config);
    rd(4'hf, VIEW.interrupt_mask);
    rd(4'h3, 8'h00);
    for (int i = 5; i < 12; i++) begin
      rd(i[3:0], 8'h00);
    end
    rd(4'h0, 8'ha2);
    $display("page 2 test done");
    wr(4'h0, 8'he2);
    wr(4'h1, 8'h4e);
    rd(4'h1, {7'h27, STATUS.eeprom_data_from_rom});
    wr(4'h4, 8'hff);
    wr(4'h5, 8'hff);
    wr(4'h6, 8'hff);
    wr(4'hc, 8'hff);
    rd(4'h4, {1'b0, STATUS.irq_line_io_base});
    rd(4'h5, {3'h0, STATUS.boot_rom_size_base});
    rd(4'h6, STATUS.power_led_status & 8'hf9);
    host.idle();
    check("flash protect locked", 64'h0, {56'h0, CONFIG.flash_write_protect});
    r = {48'h0, rnd()};
    bp = r[7:0];
    wr(4'h1, 8'hc0);
    wr(4'h4, 8'hff);
    wr(4'h5, 8'hff);
    wr(4'h6, 8'hff);
    wr(4'hc, 8'h5a);
    wr(4'h9, 8'ha5);
    wr(4'h2, bp);
    wr(4'h7, 8'hff);
    for (int i = 10; i < 16; i++) begin
      if (i != 12) begin
        wr(i[3:0], 8'hff);
      end
    end
    wr(4'h3, 8'hff);
    wr(4'h8, 8'hff);
    rd(4'h1, {7'h60, STATUS.eeprom_data_from_rom});
    rd(4'h2, bp);
    rd(4'h3, STATUS.config_straps_status & 8'hfc);
    rd(4'h4, {1'b1, STATUS.irq_line_io_base});
    rd(4'h5, {3'h7, STATUS.boot_rom_size_base});
    rd(4'h6, (STATUS.power_led_status & 8'hf9) | 8'h06);
    rd(4'h8, STATUS.saved_card_select_number);
    rd(4'hb, STATUS.interrupt_line_state);
    rd(4'hd, {7'h00, STATUS.io_mapping_status});
    rd(4'ha, 8'h00);
    rd(4'he, 8'h00);
    rd(4'hf, 8'h00);
    host.idle();
    check("clock halt", 64'ha5, {56'h0, CONFIG.clock_halt_control});
    check("flash protect", 64'h5a, {56'h0, CONFIG.flash_write_protect});
    $display("page 3 test done");
    wr(4'h0, 8'h4a);
    rd(4'h0, 8'h4a);
    wr(4'h0, 8'h52);
    rd(4'h0, 8'h52);
    wr(4'h0, 8'h42);
    rd(4'h0, 8'h52);
    rd(4'h1, v[1]);
    host.idle();
    check("COMMAND", 64'h52, {56'h0, COMMAND});
    $display("command test done");
    repeat (2) @(posedge CLK);
    finish_test();
  end
endmodule

// File: rtl/nic_regs_pkg.sv
// Package for the paged network controller register bank.
// Assumes an 8-bit host data bus with a 4-bit register offset.
package nic_regs_pkg;

  // ==========================================================================
  // Offsets
  // ==========================================================================
  localparam logic [3:0] OFS_COMMAND = 4'h0;
  localparam logic [3:0] OFS_STATION_LO = 4'h1;
  localparam logic [3:0] OFS_STATION_HI = 4'h6;
  localparam logic [3:0] OFS_CURRENT_RX = 4'h7;
  localparam logic [3:0] OFS_MCAST_LO = 4'h8;
  localparam logic [3:0] OFS_RING_START = 4'h1;
  localparam logic [3:0] OFS_RING_STOP = 4'h2;
  localparam logic [3:0] OFS_TX_START = 4'h4;
  localparam logic [3:0] OFS_RX_CONFIG = 4'hc;
  localparam logic [3:0] OFS_TX_CONFIG = 4'hd;
  localparam logic [3:0] OFS_DATA_CONFIG = 4'he;
  localparam logic [3:0] OFS_INT_MASK = 4'hf;
  localparam logic [3:0] OFS_EEPROM_CTL = 4'h1;
  localparam logic [3:0] OFS_BOOT_PAGE = 4'h2;
  localparam logic [3:0] OFS_CFG_STRAPS = 4'h3;
  localparam logic [3:0] OFS_CFG_IRQ = 4'h4;
  localparam logic [3:0] OFS_CFG_MEDIUM = 4'h5;
  localparam logic [3:0] OFS_CFG_POWER = 4'h6;
  localparam logic [3:0] OFS_TEST = 4'h7;
  localparam logic [3:0] OFS_CSN = 4'h8;
  localparam logic [3:0] OFS_CLK_HALT = 4'h9;
  localparam logic [3:0] OFS_IRQ_STATE = 4'hb;
  localparam logic [3:0] OFS_FLASH_WP = 4'hc;
  localparam logic [3:0] OFS_IO_MAP = 4'hd;

  // ==========================================================================
  // Pages, commands and write masks
  // ==========================================================================
  typedef enum logic [1:0] {
    PAGE_0 = 2'h0,
    PAGE_1 = 2'h1,
    PAGE_2 = 2'h2,
    PAGE_3 = 2'h3
  } page_type;

  localparam logic [2:0] DMA_NOT_ALLOWED = 3'h0;
  localparam logic [2:0] DMA_REMOTE_READ = 3'h1;
  localparam logic [2:0] DMA_REMOTE_WRITE = 3'h2;

  localparam logic [7:0] COMMAND_RESET = 8'h21;
  localparam logic [1:0] EEPROM_MODE_CONFIG = 2'h3;
  localparam logic [7:0] EEPROM_WMASK = 8'hce;
  localparam logic [7:0] CFG_IRQ_WMASK = 8'h80;
  localparam logic [7:0] CFG_MEDIUM_WMASK = 8'he0;
  localparam logic [7:0] CFG_POWER_WMASK = 8'h06;
  localparam logic [7:0] CFG_STRAPS_MASK = 8'hfc;
  localparam logic [7:0] IO_MAP_MASK = 8'h01;

  // ==========================================================================
  // Carriers
  // ==========================================================================
  typedef struct packed {
    logic [1:0] page_sel;
    logic [2:0] remote_dma_cmd;
    logic transmit_request;
    logic start_cmd_bit;
    logic stop_cmd_bit;
  } command_type;

  typedef struct packed {
    logic [7:0] ring_start_page;
    logic [7:0] ring_stop_page;
    logic [7:0] transmit_start_page;
    logic [7:0] receive_config;
    logic [7:0] transmit_config;
    logic [7:0] data_config;
    logic [7:0] interrupt_mask;
  } page0_view_type;

  typedef struct packed {
    logic [7:0] config_straps_status;
    logic [6:0] irq_line_io_base;
    logic [4:0] boot_rom_size_base;
    logic [7:0] power_led_status;
    logic [7:0] saved_card_select_number;
    logic [7:0] interrupt_line_state;
    logic io_mapping_status;
    logic eeprom_data_from_rom;
  } status_in_type;

  typedef struct packed {
    logic [47:0] station_address;
    logic [7:0] current_receive_page;
    logic [63:0] multicast_filter;
    logic [7:0] boot_rom_page;
    logic [1:0] eeprom_mode;
    logic eeprom_chip_select;
    logic eeprom_serial_clock;
    logic eeprom_data_to_rom;
    logic irq_output_enable;
    logic [2:0] medium_bootrom_ctl;
    logic [1:0] power_ctl;
    logic [7:0] clock_halt_control;
    logic [7:0] flash_write_protect;
  } config_out_type;

endpackage

// File: rtl/paged_nic_register_bank.sv
// Paged host register bank: command register, station address, multicast
// filter, page 0 views and the configuration page.
// Assumes a synchronous byte bus on CLK; straps and status come from pins.
`timescale 1ns/1ps
module paged_nic_register_bank (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic [3:0] ADDR,
  input wire logic RD_STB,
  input wire logic WR_STB,
  input wire logic [7:0] WDATA,
  output logic [7:0] RDATA,
  input wire nic_regs_pkg::page0_view_type VIEW,
  input wire nic_regs_pkg::status_in_type STATUS,
  output nic_regs_pkg::command_type COMMAND,
  output nic_regs_pkg::config_out_type CONFIG
);

  // ==========================================================================
  // Reset release and pin synchroniser
  // ==========================================================================
  logic [1:0] rst_sync_q;
  logic rst_n;
  nic_regs_pkg::status_in_type status_meta_q;
  nic_regs_pkg::status_in_type status_sync_q;

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      status_meta_q <= '0;
      status_sync_q <= '0;
    end else begin
      status_meta_q <= STATUS;
      status_sync_q <= status_meta_q;
    end
  end

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    nic_regs_pkg::command_type command;
    nic_regs_pkg::config_out_type cfg;
    logic [7:0] rdata;
  } state_type;

  state_type state_q;
  state_type state_d;
  nic_regs_pkg::page_type page;
  logic config_mode;
  logic [7:0] read_value;

  assign page = nic_regs_pkg::page_type'(state_q.command.page_sel);
  assign config_mode = state_q.cfg.eeprom_mode == nic_regs_pkg::EEPROM_MODE_CONFIG;

  // ==========================================================================
  // Read multiplexer
  // ==========================================================================
  always_comb begin
    read_value = 8'h00;
    if (ADDR == nic_regs_pkg::OFS_COMMAND) begin
      read_value = state_q.command;
    end else begin
      case (page)
        nic_regs_pkg::PAGE_1: begin
          if (ADDR <= nic_regs_pkg::OFS_STATION_HI) begin
            read_value = state_q.cfg.station_address[8*(ADDR-4'h1) +: 8];
          end else if (ADDR == nic_regs_pkg::OFS_CURRENT_RX) begin
            read_value = state_q.cfg.current_receive_page;
          end else begin
            read_value = state_q.cfg.multicast_filter[8*(ADDR-nic_regs_pkg::OFS_MCAST_LO) +: 8];
          end
        end
        nic_regs_pkg::PAGE_2: begin
          case (ADDR)
            nic_regs_pkg::OFS_RING_START: read_value = VIEW.ring_start_page;
            nic_regs_pkg::OFS_RING_STOP: read_value = VIEW.ring_stop_page;
            nic_regs_pkg::OFS_TX_START: read_value = VIEW.transmit_start_page;
            nic_regs_pkg::OFS_RX_CONFIG: read_value = VIEW.receive_config;
            nic_regs_pkg::OFS_TX_CONFIG: read_value = VIEW.transmit_config;
            nic_regs_pkg::OFS_DATA_CONFIG: read_value = VIEW.data_config;
            nic_regs_pkg::OFS_INT_MASK: read_value = VIEW.interrupt_mask;
            default: read_value = 8'h00;
          endcase
        end
        nic_regs_pkg::PAGE_3: begin
          case (ADDR)
            nic_regs_pkg::OFS_EEPROM_CTL: begin
              read_value = {state_q.cfg.eeprom_mode, 2'h0, state_q.cfg.eeprom_chip_select,
                state_q.cfg.eeprom_serial_clock, state_q.cfg.eeprom_data_to_rom,
                status_sync_q.eeprom_data_from_rom};
            end
            nic_regs_pkg::OFS_BOOT_PAGE: read_value = state_q.cfg.boot_rom_page;
            nic_regs_pkg::OFS_CFG_STRAPS: begin
              read_value = status_sync_q.config_straps_status & nic_regs_pkg::CFG_STRAPS_MASK;
            end
            nic_regs_pkg::OFS_CFG_IRQ: begin
              read_value = {state_q.cfg.irq_output_enable, status_sync_q.irq_line_io_base};
            end
            nic_regs_pkg::OFS_CFG_MEDIUM: begin
              read_value = {state_q.cfg.medium_bootrom_ctl, status_sync_q.boot_rom_size_base};
            end
            nic_regs_pkg::OFS_CFG_POWER: begin
              read_value = (status_sync_q.power_led_status & ~nic_regs_pkg::CFG_POWER_WMASK)
                | {5'h00, state_q.cfg.power_ctl, 1'b0};
            end
            nic_regs_pkg::OFS_CSN: read_value = status_sync_q.saved_card_select_number;
            nic_regs_pkg::OFS_IRQ_STATE: read_value = status_sync_q.interrupt_line_state;
            nic_regs_pkg::OFS_IO_MAP: read_value = {7'h00, status_sync_q.io_mapping_status};
            default: read_value = 8'h00;
          endcase
        end
        default: read_value = 8'h00;
      endcase
    end
  end

  // ==========================================================================
  // Write decode and next state
  // ==========================================================================
  always_comb begin
    state_d = state_q;
    if (RD_STB) begin
      state_d.rdata = read_value;
    end
    if (WR_STB) begin
      if (ADDR == nic_regs_pkg::OFS_COMMAND) begin
        state_d.command = WDATA;
        if (WDATA[5:3] == nic_regs_pkg::DMA_NOT_ALLOWED) begin
          state_d.command.remote_dma_cmd = state_q.command.remote_dma_cmd;
        end
      end else begin
        case (page)
          nic_regs_pkg::PAGE_1: begin
            if (ADDR <= nic_regs_pkg::OFS_STATION_HI) begin
              state_d.cfg.station_address[8*(ADDR-4'h1) +: 8] = WDATA;
            end else if (ADDR == nic_regs_pkg::OFS_CURRENT_RX) begin
              state_d.cfg.current_receive_page = WDATA;
            end else begin
              state_d.cfg.multicast_filter[8*(ADDR-nic_regs_pkg::OFS_MCAST_LO) +: 8] = WDATA;
            end
          end
          nic_regs_pkg::PAGE_3: begin
            case (ADDR)
              nic_regs_pkg::OFS_EEPROM_CTL: begin
                state_d.cfg.eeprom_mode = WDATA[7:6];
                state_d.cfg.eeprom_chip_select = WDATA[3];
                state_d.cfg.eeprom_serial_clock = WDATA[2];
                state_d.cfg.eeprom_data_to_rom = WDATA[1];
              end
              nic_regs_pkg::OFS_BOOT_PAGE: state_d.cfg.boot_rom_page = WDATA;
              nic_regs_pkg::OFS_CFG_IRQ: begin
                if (config_mode) begin
                  state_d.cfg.irq_output_enable = WDATA[7];
                end
              end
              nic_regs_pkg::OFS_CFG_MEDIUM: begin
                if (config_mode) begin
                  state_d.cfg.medium_bootrom_ctl = WDATA[7:5];
                end
              end
              nic_regs_pkg::OFS_CFG_POWER: begin
                if (config_mode) begin
                  state_d.cfg.power_ctl = WDATA[2:1];
                end
              end
              nic_regs_pkg::OFS_CLK_HALT: state_d.cfg.clock_halt_control = WDATA;
              nic_regs_pkg::OFS_FLASH_WP: begin
                if (config_mode) begin
                  state_d.cfg.flash_write_protect = WDATA;
                end
              end
              default: begin
              end
            endcase
          end
          default: begin
          end
        endcase
      end
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= '0;
      state_q.command <= nic_regs_pkg::COMMAND_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  assign RDATA = state_q.rdata;
  assign COMMAND = state_q.command;
  assign CONFIG = state_q.cfg;

  // ==========================================================================
  // Checks
  // ==========================================================================
  sequence guard_closed_s;
    WR_STB && page == nic_regs_pkg::PAGE_3 && ADDR == nic_regs_pkg::OFS_CFG_IRQ && !config_mode;
  endsequence

  sequence guard_open_s;
    WR_STB && page == nic_regs_pkg::PAGE_3 && ADDR == nic_regs_pkg::OFS_CFG_IRQ && config_mode;
  endsequence

  AST_CMD_READ: assert property (@(posedge CLK) disable iff (!rst_n)
    RD_STB && ADDR == nic_regs_pkg::OFS_COMMAND |=> RDATA == $past(state_q.command))
    else $error("Command read mismatch");
  AST_PAGE_SWITCH: assert property (@(posedge CLK) disable iff (!rst_n)
    WR_STB && ADDR == nic_regs_pkg::OFS_COMMAND |=> COMMAND.page_sel == $past(WDATA[7:6]))
    else $error("Page select not taken");
  AST_DMA_NOZERO: assert property (@(posedge CLK) disable iff (!rst_n)
    COMMAND.remote_dma_cmd != nic_regs_pkg::DMA_NOT_ALLOWED)
    else $error("Remote DMA field zero");
  AST_STATION_WRITE: assert property (@(posedge CLK) disable iff (!rst_n)
    WR_STB && page == nic_regs_pkg::PAGE_1 && ADDR == nic_regs_pkg::OFS_STATION_LO
    |=> CONFIG.station_address[7:0] == $past(WDATA))
    else $error("Station byte zero not written");
  AST_MCAST_WRITE: assert property (@(posedge CLK) disable iff (!rst_n)
    WR_STB && page == nic_regs_pkg::PAGE_1 && ADDR == nic_regs_pkg::OFS_INT_MASK
    |=> CONFIG.multicast_filter[63:56] == $past(WDATA))
    else $error("Multicast top byte not written");
  AST_GUARD: assert property (@(posedge CLK) disable iff (!rst_n)
    guard_closed_s |=> $stable(CONFIG.irq_output_enable))
    else $error("Guarded write took effect");
  AST_GUARD_OPEN: assert property (@(posedge CLK) disable iff (!rst_n)
    guard_open_s |=> CONFIG.irq_output_enable == $past(WDATA[7]))
    else $error("Irq enable write lost");
  AST_RSVD_READ: assert property (@(posedge CLK) disable iff (!rst_n)
    RD_STB && page == nic_regs_pkg::PAGE_2 && ADDR == nic_regs_pkg::OFS_CFG_STRAPS
    |=> RDATA == 8'h00)
    else $error("Reserved read not zero");
  AST_STRAP_LOW: assert property (@(posedge CLK) disable iff (!rst_n)
    RD_STB && page == nic_regs_pkg::PAGE_3 && ADDR == nic_regs_pkg::OFS_CFG_STRAPS
    |=> RDATA[1:0] == 2'h0)
    else $error("Strap low bits not zero");

  // ==========================================================================
  // Checks per register
  // ==========================================================================
  // A write that a register accepts lands one cycle later; every read shows up in RDATA one cycle later.
  AST_STATION_TOP: assert property (@(posedge CLK) disable iff (!rst_n)
    WR_STB && page == nic_regs_pkg::PAGE_1 && ADDR == nic_regs_pkg::OFS_STATION_HI
    |=> CONFIG.station_address[47:40] == $past(WDATA))
    else $error("Station top byte not written");
  AST_RX_PAGE_WRITE: assert property (@(posedge CLK) disable iff (!rst_n)
    WR_STB && page == nic_regs_pkg::PAGE_1 && ADDR == nic_regs_pkg::OFS_CURRENT_RX
    |=> CONFIG.current_receive_page == $past(WDATA))
    else $error("Current receive page not written");
  AST_MCAST_LOW: assert property (@(posedge CLK) disable iff (!rst_n)
    WR_STB && page == nic_regs_pkg::PAGE_1 && ADDR == nic_regs_pkg::OFS_MCAST_LO
    |=> CONFIG.multicast_filter[7:0] == $past(WDATA))
    else $error("Multicast low byte not written");
  AST_PAGE_KEEP: assert property (@(posedge CLK) disable iff (!rst_n)
    WR_STB && ADDR == nic_regs_pkg::OFS_COMMAND
    |=> $stable(CONFIG))
    else $error("Page change disturbed registers");

  AST_RING_START_READ: assert property (@(posedge CLK) disable iff (!rst_n)
    RD_STB && page == nic_regs_pkg::PAGE_2 && ADDR == nic_regs_pkg::OFS_RING_START
    |=> RDATA == $past(VIEW.ring_start_page))
    else $error("Ring start view mismatch");
  AST_RING_STOP_READ: assert property (@(posedge CLK) disable iff (!rst_n)
    RD_STB && page == nic_regs_pkg::PAGE_2 && ADDR == nic_regs_pkg::OFS_RING_STOP
    |=> RDATA == $past(VIEW.ring_stop_page))
    else $error("Ring stop view mismatch");
  AST_TX_START_READ: assert property (@(posedge CLK) disable iff (!rst_n)
    RD_STB && page == nic_regs_pkg::PAGE_2 && ADDR == nic_regs_pkg::OFS_TX_START
    |=> RDATA == $past(VIEW.transmit_start_page))
    else $error("Transmit start view mismatch");
  AST_INT_MASK_READ: assert property (@(posedge CLK) disable iff (!rst_n)
    RD_STB && page == nic_regs_pkg::PAGE_2 && ADDR == nic_regs_pkg::OFS_INT_MASK
    |=> RDATA == $past(VIEW.interrupt_mask))
    else $error("Interrupt mask view mismatch");
  AST_PAGE2_NO_WRITE: assert property (@(posedge CLK) disable iff (!rst_n)
    WR_STB && page == nic_regs_pkg::PAGE_2 && ADDR != nic_regs_pkg::OFS_COMMAND
    |=> $stable(CONFIG))
    else $error("Page 2 write changed state");

  AST_EEPROM_MODE: assert property (@(posedge CLK) disable iff (!rst_n)
    WR_STB && page == nic_regs_pkg::PAGE_3 && ADDR == nic_regs_pkg::OFS_EEPROM_CTL
    |=> CONFIG.eeprom_mode == $past(WDATA[7:6]))
    else $error("EEPROM mode not written");
  AST_EEPROM_PINS: assert property (@(posedge CLK) disable iff (!rst_n)
    WR_STB && page == nic_regs_pkg::PAGE_3 && ADDR == nic_regs_pkg::OFS_EEPROM_CTL
    |=> {CONFIG.eeprom_chip_select, CONFIG.eeprom_serial_clock, CONFIG.eeprom_data_to_rom} == $past(WDATA[3:1]))
    else $error("EEPROM pin bits not written");
  AST_EEPROM_READ: assert property (@(posedge CLK) disable iff (!rst_n)
    RD_STB && page == nic_regs_pkg::PAGE_3 && ADDR == nic_regs_pkg::OFS_EEPROM_CTL
    |=> RDATA[0] == $past(status_sync_q.eeprom_data_from_rom))
    else $error("EEPROM data-in bit mismatch");
  AST_BOOT_PAGE_WRITE: assert property (@(posedge CLK) disable iff (!rst_n)
    WR_STB && page == nic_regs_pkg::PAGE_3 && ADDR == nic_regs_pkg::OFS_BOOT_PAGE
    |=> CONFIG.boot_rom_page == $past(WDATA))
    else $error("Boot page not written");

  AST_MEDIUM_OPEN: assert property (@(posedge CLK) disable iff (!rst_n)
    WR_STB && page == nic_regs_pkg::PAGE_3 && ADDR == nic_regs_pkg::OFS_CFG_MEDIUM && config_mode
    |=> CONFIG.medium_bootrom_ctl == $past(WDATA[7:5]))
    else $error("Medium bits not written");
  AST_MEDIUM_LOCK: assert property (@(posedge CLK) disable iff (!rst_n)
    WR_STB && page == nic_regs_pkg::PAGE_3 && ADDR == nic_regs_pkg::OFS_CFG_MEDIUM && !config_mode
    |=> $stable(CONFIG.medium_bootrom_ctl))
    else $error("Locked medium write took effect");
  AST_POWER_OPEN: assert property (@(posedge CLK) disable iff (!rst_n)
    WR_STB && page == nic_regs_pkg::PAGE_3 && ADDR == nic_regs_pkg::OFS_CFG_POWER && config_mode
    |=> CONFIG.power_ctl == $past(WDATA[2:1]))
    else $error("Power bits not written");
  AST_POWER_LOCK: assert property (@(posedge CLK) disable iff (!rst_n)
    WR_STB && page == nic_regs_pkg::PAGE_3 && ADDR == nic_regs_pkg::OFS_CFG_POWER && !config_mode
    |=> $stable(CONFIG.power_ctl))
    else $error("Locked power write took effect");

  AST_FLASH_OPEN: assert property (@(posedge CLK) disable iff (!rst_n)
    WR_STB && page == nic_regs_pkg::PAGE_3 && ADDR == nic_regs_pkg::OFS_FLASH_WP && config_mode
    |=> CONFIG.flash_write_protect == $past(WDATA))
    else $error("Flash protect not written");
  AST_FLASH_LOCK: assert property (@(posedge CLK) disable iff (!rst_n)
    WR_STB && page == nic_regs_pkg::PAGE_3 && ADDR == nic_regs_pkg::OFS_FLASH_WP && !config_mode
    |=> $stable(CONFIG.flash_write_protect))
    else $error("Locked flash write took effect");
  AST_HALT_WRITE: assert property (@(posedge CLK) disable iff (!rst_n)
    WR_STB && page == nic_regs_pkg::PAGE_3 && ADDR == nic_regs_pkg::OFS_CLK_HALT
    |=> CONFIG.clock_halt_control == $past(WDATA))
    else $error("Clock halt not written");
  AST_CSN_READ: assert property (@(posedge CLK) disable iff (!rst_n)
    RD_STB && page == nic_regs_pkg::PAGE_3 && ADDR == nic_regs_pkg::OFS_CSN
    |=> RDATA == $past(status_sync_q.saved_card_select_number))
    else $error("Card select number mismatch");

  AST_IRQ_STATE_READ: assert property (@(posedge CLK) disable iff (!rst_n)
    RD_STB && page == nic_regs_pkg::PAGE_3 && ADDR == nic_regs_pkg::OFS_IRQ_STATE
    |=> RDATA == $past(status_sync_q.interrupt_line_state))
    else $error("Interrupt line state mismatch");
  AST_IO_MAP_READ: assert property (@(posedge CLK) disable iff (!rst_n)
    RD_STB && page == nic_regs_pkg::PAGE_3 && ADDR == nic_regs_pkg::OFS_IO_MAP
    |=> RDATA == {7'h00, $past(status_sync_q.io_mapping_status)})
    else $error("I/O mapping status mismatch");
  AST_STRAPS_READ: assert property (@(posedge CLK) disable iff (!rst_n)
    RD_STB && page == nic_regs_pkg::PAGE_3 && ADDR == nic_regs_pkg::OFS_CFG_STRAPS
    |=> RDATA[7:2] == $past(status_sync_q.config_straps_status[7:2]))
    else $error("Strap bits mismatch");

endmodule
